// *** prbs_test_defs.svh ***
`ifndef PRBS_TEST_DEFS_SVH
`define PRBS_TEST_DEFS_SVH

// Register indices; the APB byte address is four times the index.
`define IDX_FRAMER_SEL 8'h0F
`define IDX_DET_CTRL 8'h60
`define IDX_DET_STAT 8'h61
`define IDX_SHIFT_LEN 8'h62
`define IDX_FB_TAP 8'h63
`define IDX_ERR_INJ 8'h64
`define IDX_SEED0 8'h68
`define IDX_SEED1 8'h69
`define IDX_SEED2 8'h6A
`define IDX_SEED_LOAD 8'h6B
`define IDX_ERRCNT0 8'h6C
`define IDX_ERRCNT1 8'h6D
`define IDX_ERRCNT2 8'h6E
`define IDX_ERRCNT3 8'h6F
`define IDX_INT_STAT 8'h70
`define IDX_INT_MASK 8'h71
`define IDX_FRAMER_RST 8'h8A
`define IDX_TX_EN 8'hB0
`define IDX_TX_CHAN 8'hB2
`define IDX_TX_DATA 8'hB3
`define IDX_RX_EN 8'hD0
`define IDX_RX_CHAN 8'hD2
`define IDX_RX_DATA 8'hD3

// Field positions.
`define CTL_COUNT_MODE 7
`define CTL_TX_INV 5
`define CTL_RX_INV 4
`define CTL_AUTO_RESYNC 1
`define CTL_FORCE_RESYNC 0
`define STAT_SYNC 4
`define STAT_BIT_ERR 2
`define INJ_BIT 3
`define LOOPBACK_BIT 2
`define PAYLOAD_TEST_BIT 3
`define ACCESS_EN_BIT 0
`define INT_SYNC_GAIN 0
`define INT_SYNC_LOSS 1
`define INT_BIT_ERR 2

// Reset values.
`define RST_BYTE 8'h00
`define RST_SEED_BYTE 8'hFF
`define RST_LEN 8'h18
`define RST_TAP 8'h02

// Detector thresholds, in checked bits.
`define SYNC_MATCHES 6'd32
`define LOSS_ERRORS 3'd4

`endif

// *** prbs_test_pkg.sv ***
package prbs_test_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] chan;
		logic data;
	} slot_bit_t;

	typedef struct packed {
		logic valid;
		logic data;
	} line_bit_t;

	typedef enum logic [0:0] {
		DET_HUNT = 1'b0,
		DET_SYNC = 1'b1
	} det_state_t;
endpackage : prbs_test_pkg

// *** prbs_channel_test_engine.sv ***
`timescale 1ns/1ns
`include "prbs_test_defs.svh"
module prbs_channel_test_engine (
	input wire logic pclk, // APB clock, 25 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic irq, // Level interrupt
	output logic [2:0] framer_sel, // Framer under test, zero based
	output logic diag_loopback, // Digital loopback for the selected framer
	input prbs_test_pkg::slot_bit_t tx_in, // Transmit payload bit from the framer
	output prbs_test_pkg::line_bit_t tx_out, // Transmit payload bit to the line
	input prbs_test_pkg::slot_bit_t rx_in // Receive payload bit from the line
);
	logic [7:0] framer_sel_r;
	logic [7:0] det_ctrl_r;
	logic [7:0] shift_len_r;
	logic [7:0] fb_tap_r;
	logic [7:0] err_inj_r;
	logic [7:0] seed_r [0:3];
	logic [7:0] framer_rst_r;
	logic [7:0] tx_en_r;
	logic [7:0] tx_chan_r;
	logic [7:0] tx_data_r;
	logic [7:0] rx_en_r;
	logic [7:0] rx_chan_r;
	logic [7:0] rx_data_r;
	logic [7:0] int_stat_r;
	logic [7:0] int_mask_r;
	logic [7:0] tx_tab [0:127];
	logic [7:0] rx_tab [0:31];
	logic [31:0] gen_r;
	logic [31:0] det_r;
	logic [31:0] run_cnt_r;
	logic [31:0] held_cnt_r;
	logic [5:0] match_cnt_r;
	logic [2:0] loss_cnt_r;
	logic bit_err_r;
	logic inj_pend_r;
	prbs_test_pkg::det_state_t det_state_r;
	prbs_test_pkg::det_state_t det_state_nxt;

	logic [7:0] idx;
	logic wr;
	logic rd;
	logic [7:0] rd_byte;
	logic mapped;
	logic tx_hit;
	logic rx_hit;
	logic gen_bit;
	logic rx_bit;
	logic rx_mismatch;
	logic sync_gain;
	logic sync_loss;
	logic err_event;
	logic [7:0] int_set;

	// Feedback bit of the shared polynomial: the bit at the programmed length xor the tap.
	function automatic logic lfsr_fb(input logic [31:0] s, input logic [7:0] len, input logic [7:0] tap);
		lfsr_fb = s[len[4:0]] ^ s[tap[4:0]];
	endfunction : lfsr_fb

	function automatic logic [31:0] lfsr_shift(input logic [31:0] s, input logic b);
		lfsr_shift = {s[30:0], b};
	endfunction : lfsr_shift

	assign idx = paddr[9:2];
	assign wr = psel & penable & pready & pwrite & (paddr[11:10] == 2'b00);
	assign rd = psel & penable & pready & ~pwrite & (paddr[11:10] == 2'b00);

	always_comb
	begin
		mapped = 1'b1;
		rd_byte = `RST_BYTE;
		unique case (idx)
			`IDX_FRAMER_SEL: rd_byte = framer_sel_r;
			`IDX_DET_CTRL: rd_byte = det_ctrl_r;
			`IDX_DET_STAT: rd_byte = {3'b000, det_state_r == prbs_test_pkg::DET_SYNC, 1'b0, bit_err_r, 2'b00};
			`IDX_SHIFT_LEN: rd_byte = shift_len_r;
			`IDX_FB_TAP: rd_byte = fb_tap_r;
			`IDX_ERR_INJ: rd_byte = err_inj_r;
			`IDX_SEED0: rd_byte = seed_r[0];
			`IDX_SEED1: rd_byte = seed_r[1];
			`IDX_SEED2: rd_byte = seed_r[2];
			`IDX_SEED_LOAD: rd_byte = seed_r[3];
			`IDX_ERRCNT0: rd_byte = held_cnt_r[7:0];
			`IDX_ERRCNT1: rd_byte = held_cnt_r[15:8];
			`IDX_ERRCNT2: rd_byte = held_cnt_r[23:16];
			`IDX_ERRCNT3: rd_byte = held_cnt_r[31:24];
			`IDX_INT_STAT: rd_byte = int_stat_r;
			`IDX_INT_MASK: rd_byte = int_mask_r;
			`IDX_FRAMER_RST: rd_byte = framer_rst_r;
			`IDX_TX_EN: rd_byte = tx_en_r;
			`IDX_TX_CHAN: rd_byte = tx_chan_r;
			`IDX_TX_DATA: rd_byte = tx_data_r;
			`IDX_RX_EN: rd_byte = rx_en_r;
			`IDX_RX_CHAN: rd_byte = rx_chan_r;
			`IDX_RX_DATA: rd_byte = rx_data_r;
			default: mapped = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00)
		begin
			mapped = 1'b0;
		end
	end

	// Zero wait states: the answer is prepared in the setup cycle so every bus output is a flop.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite & mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			framer_sel_r <= `RST_BYTE;
			det_ctrl_r <= `RST_BYTE;
			shift_len_r <= `RST_LEN;
			fb_tap_r <= `RST_TAP;
			err_inj_r <= `RST_BYTE;
			framer_rst_r <= `RST_BYTE;
			tx_en_r <= `RST_BYTE;
			tx_chan_r <= `RST_BYTE;
			tx_data_r <= `RST_BYTE;
			rx_en_r <= `RST_BYTE;
			rx_chan_r <= `RST_BYTE;
			rx_data_r <= `RST_BYTE;
			int_mask_r <= `RST_BYTE;
			for (int i = 0; i < 4; i++)
			begin
				seed_r[i] <= `RST_SEED_BYTE;
			end
		end
		else if (wr && mapped)
		begin
			unique case (idx)
				`IDX_FRAMER_SEL: framer_sel_r <= pwdata[7:0];
				`IDX_DET_CTRL: det_ctrl_r <= pwdata[7:0];
				`IDX_SHIFT_LEN: shift_len_r <= pwdata[7:0];
				`IDX_FB_TAP: fb_tap_r <= pwdata[7:0];
				`IDX_ERR_INJ: err_inj_r <= pwdata[7:0];
				`IDX_SEED0: seed_r[0] <= pwdata[7:0];
				`IDX_SEED1: seed_r[1] <= pwdata[7:0];
				`IDX_SEED2: seed_r[2] <= pwdata[7:0];
				`IDX_SEED_LOAD: seed_r[3] <= pwdata[7:0];
				`IDX_INT_MASK: int_mask_r <= pwdata[7:0];
				`IDX_FRAMER_RST: framer_rst_r <= pwdata[7:0];
				`IDX_TX_EN: tx_en_r <= pwdata[7:0];
				`IDX_TX_CHAN: tx_chan_r <= pwdata[7:0];
				`IDX_TX_DATA: tx_data_r <= pwdata[7:0];
				`IDX_RX_EN: rx_en_r <= pwdata[7:0];
				`IDX_RX_CHAN: rx_chan_r <= pwdata[7:0];
				`IDX_RX_DATA: rx_data_r <= pwdata[7:0];
				default:
				begin
				end
			endcase
		end
	end

	// The tables are cleared at reset as well, so an unmarked slot never carries an unknown marking.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 128; i++)
			begin
				tx_tab[i] <= `RST_BYTE;
			end
			for (int i = 0; i < 32; i++)
			begin
				rx_tab[i] <= `RST_BYTE;
			end
		end
		else if (wr)
		begin
			if (idx == `IDX_TX_CHAN && tx_en_r[`ACCESS_EN_BIT])
			begin
				tx_tab[pwdata[6:0]] <= tx_data_r;
			end
			if (idx == `IDX_RX_CHAN && rx_en_r[`ACCESS_EN_BIT])
			begin
				rx_tab[pwdata[4:0]] <= rx_data_r;
			end
		end
	end

	assign tx_hit = tx_in.valid & tx_tab[tx_in.chan[6:0]][`PAYLOAD_TEST_BIT] & ~tx_in.chan[7];
	assign rx_hit = rx_in.valid & rx_tab[rx_in.chan[4:0]][`PAYLOAD_TEST_BIT] & (rx_in.chan[7:5] == 3'b000);
	assign gen_bit = lfsr_fb(gen_r, shift_len_r, fb_tap_r);

	// One error per rising edge of the inject bit; holding it high adds no more.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			inj_pend_r <= 1'b0;
		end
		else if (wr && idx == `IDX_ERR_INJ && pwdata[`INJ_BIT] && !err_inj_r[`INJ_BIT])
		begin
			inj_pend_r <= 1'b1;
		end
		else if (tx_hit)
		begin
			inj_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gen_r <= 32'hFFFF_FFFF;
		end
		else if (wr && idx == `IDX_SEED_LOAD)
		begin
			gen_r <= {pwdata[7:0], seed_r[2], seed_r[1], seed_r[0]};
		end
		else if (tx_hit)
		begin
			gen_r <= lfsr_shift(gen_r, gen_bit);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_out <= '0;
		end
		else
		begin
			tx_out.valid <= tx_in.valid;
			tx_out.data <= tx_hit ? (gen_bit ^ det_ctrl_r[`CTL_TX_INV] ^ inj_pend_r) : tx_in.data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			framer_sel <= 3'b000;
			diag_loopback <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			framer_sel <= framer_sel_r[7:5];
			diag_loopback <= framer_rst_r[`LOOPBACK_BIT];
			irq <= |(int_stat_r & int_mask_r);
		end
	end

	// The detector is self-synchronising: it shifts in received bits, so it locks without a seed.
	assign rx_bit = rx_in.data ^ det_ctrl_r[`CTL_RX_INV];
	assign rx_mismatch = lfsr_fb(det_r, shift_len_r, fb_tap_r) != rx_bit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			det_r <= 32'h0000_0000;
		end
		else if (rx_hit)
		begin
			det_r <= lfsr_shift(det_r, rx_bit);
		end
	end

	always_comb
	begin
		det_state_nxt = det_state_r;
		unique case (det_state_r)
			prbs_test_pkg::DET_HUNT:
			begin
				if (rx_hit && !rx_mismatch && match_cnt_r == `SYNC_MATCHES - 6'd1)
				begin
					det_state_nxt = prbs_test_pkg::DET_SYNC;
				end
			end
			prbs_test_pkg::DET_SYNC:
			begin
				if (rx_hit && rx_mismatch && det_ctrl_r[`CTL_AUTO_RESYNC] && loss_cnt_r == `LOSS_ERRORS - 3'd1)
				begin
					det_state_nxt = prbs_test_pkg::DET_HUNT;
				end
			end
		endcase
		if (wr && idx == `IDX_DET_CTRL && pwdata[`CTL_FORCE_RESYNC])
		begin
			det_state_nxt = prbs_test_pkg::DET_HUNT;
		end
	end

	assign sync_gain = det_state_r == prbs_test_pkg::DET_HUNT && det_state_nxt == prbs_test_pkg::DET_SYNC;
	assign sync_loss = det_state_r == prbs_test_pkg::DET_SYNC && det_state_nxt == prbs_test_pkg::DET_HUNT;
	assign err_event = rx_hit && rx_mismatch && det_state_r == prbs_test_pkg::DET_SYNC;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			det_state_r <= prbs_test_pkg::DET_HUNT;
			match_cnt_r <= 6'd0;
			loss_cnt_r <= 3'd0;
		end
		else
		begin
			det_state_r <= det_state_nxt;
			if (det_state_nxt != det_state_r)
			begin
				match_cnt_r <= 6'd0;
				loss_cnt_r <= 3'd0;
			end
			else if (rx_hit)
			begin
				match_cnt_r <= rx_mismatch ? 6'd0 : match_cnt_r + 6'd1;
				loss_cnt_r <= rx_mismatch ? loss_cnt_r + 3'd1 : 3'd0;
			end
		end
	end

	// In counter mode only errors are counted; otherwise every checked bit is, to measure test length.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_cnt_r <= 32'h0000_0000;
			held_cnt_r <= 32'h0000_0000;
		end
		else if (wr && idx == `IDX_ERRCNT0)
		begin
			held_cnt_r <= run_cnt_r;
			run_cnt_r <= 32'h0000_0000;
		end
		else if (det_ctrl_r[`CTL_COUNT_MODE] ? err_event : rx_hit)
		begin
			run_cnt_r <= run_cnt_r + 32'h0000_0001;
		end
	end

	// Bit error indication is sticky until status is read; an error in the read cycle wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_err_r <= 1'b0;
		end
		else if (err_event)
		begin
			bit_err_r <= 1'b1;
		end
		else if (rd && idx == `IDX_DET_STAT)
		begin
			bit_err_r <= 1'b0;
		end
	end

	always_comb
	begin
		int_set = 8'h00;
		int_set[`INT_SYNC_GAIN] = sync_gain;
		int_set[`INT_SYNC_LOSS] = sync_loss;
		int_set[`INT_BIT_ERR] = err_event;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_stat_r <= `RST_BYTE;
		end
		else if (wr && idx == `IDX_INT_STAT)
		begin
			int_stat_r <= (int_stat_r & ~pwdata[7:0]) | int_set;
		end
		else
		begin
			int_stat_r <= int_stat_r | int_set;
		end
	end
endmodule : prbs_channel_test_engine

// *** prbs_engine_assertions.sv ***
`timescale 1ns/1ns
`include "prbs_test_defs.svh"
module prbs_engine_assertions (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Write
	input wire logic [11:0] paddr, // Byte address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic irq, // Interrupt
	input wire logic [2:0] framer_sel, // Framer under test
	input wire logic diag_loopback, // Loopback
	input prbs_test_pkg::slot_bit_t tx_in, // Transmit in
	input prbs_test_pkg::line_bit_t tx_out, // Transmit out
	input prbs_test_pkg::slot_bit_t rx_in // Receive in
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr;
	logic sel_wr;
	logic lb_wr;
	assign wr = psel && penable && pready && pwrite && paddr[11:10] == 2'h0;
	assign sel_wr = wr && paddr[9:2] == `IDX_FRAMER_SEL;
	assign lb_wr = wr && paddr[9:2] == `IDX_FRAMER_RST;
	// The register and the output flop each add one edge, so the pin follows two edges after the write.
	a_select_follows: assert property (sel_wr |=> ##1 framer_sel == $past(pwdata[7:5], 2))
		else $error("framer select not updated");
	a_select_holds: assert property (!sel_wr |-> ##2 $stable(framer_sel))
		else $error("framer select changed");
	a_loopback_follows: assert property (lb_wr |=> ##1 diag_loopback == $past(pwdata[2], 2))
		else $error("loopback not updated");
	a_loopback_holds: assert property (!lb_wr |-> ##2 $stable(diag_loopback))
		else $error("loopback changed");
	a_tx_bit_follows: assert property (tx_in.valid |=> tx_out.valid)
		else $error("transmit bit lost");
	a_tx_idle_follows: assert property (!tx_in.valid |=> !tx_out.valid)
		else $error("transmit bit invented");
	a_reg_zero_wait: assert property (psel && !penable |=> pready)
		else $error("register access not answered");
	a_read_byte_only: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
endmodule : prbs_engine_assertions
bind prbs_channel_test_engine prbs_engine_assertions i_prbs_engine_assertions (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .framer_sel(framer_sel), .diag_loopback(diag_loopback),
	.tx_in(tx_in), .tx_out(tx_out), .rx_in(rx_in));

// *** far_end_loop.sv ***
`timescale 1ns/1ns
module far_end_loop (
	input wire logic pclk, // Line clock
	input wire logic presetn, // Reset, active low
	input prbs_test_pkg::line_bit_t line_tx, // Bit from the near end
	input wire logic [7:0] line_chan, // Timeslot of that bit
	output prbs_test_pkg::slot_bit_t rx_bit // Bit looped back
);
	// An idle line shows the inverse of its last bit so stale data is never mistaken for traffic.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_bit <= '0;
		else
			rx_bit <= '{line_tx.valid, line_chan, line_tx.valid ? line_tx.data : ~rx_bit.data};
	end
endmodule : far_end_loop

// *** tb.sv ***
`timescale 1ns/1ns
`include "prbs_test_defs.svh"
module tb;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, irq, diag_loopback, rd_err;
	logic [2:0] framer_sel;
	logic run = 1'h0;
	logic pv = 1'h0;
	logic line_data = 1'h0;
	logic [7:0] line_chan = 8'h00;
	logic [7:0] rd;
	logic [31:0] g = 32'hFFFF_FF5A;
	logic inv = 1'h0;
	logic [7:0] cfg_a [9] = '{8'h0F, 8'h60, 8'h62, 8'h63, 8'h68, 8'h6B, 8'h8A, 8'hB0, 8'hD0};
	logic [7:0] cfg_d [9] = '{8'h20, 8'h82, 8'h18, 8'h02, 8'h5A, 8'hFF, 8'h04, 8'h01, 8'h01};
	prbs_test_pkg::slot_bit_t tx_in = '0;
	prbs_test_pkg::slot_bit_t rx_in;
	prbs_test_pkg::line_bit_t tx_out;
	int failures = 0;
	int checked = 0;
	int tx_err = 0;
	prbs_channel_test_engine i_prbs_channel_test_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .framer_sel(framer_sel), .diag_loopback(diag_loopback), .tx_in(tx_in),
		.tx_out(tx_out), .rx_in(rx_in));
	far_end_loop i_far_end_loop (.pclk(pclk), .presetn(presetn), .line_tx(tx_out), .line_chan(line_chan),
		.rx_bit(rx_in));
	always #20 pclk = ~pclk;
	task automatic fail(input string m);
		$display("unexpected %0t %s", $time, m);
		failures++;
	endtask : fail
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp)
			fail(m);
	endtask : chk
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd = prdata[7:0];
		rd_err = pslverr;
		if (pready !== 1'h1)
		begin
			fail("no ready");
			stop_test;
		end
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		apb(1'h0, idx, 8'h00);
		chk(rd, exp, "register value");
	endtask : rdc
	task automatic stop_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Slots cycle 1..24; the framer's own data is varied so pass-through is visible.
	always @(posedge pclk)
	begin
		tx_in <= '{run, tx_in.chan % 8'h18 + 8'h01, tx_in.chan[1]};
		pv <= tx_in.valid;
		line_chan <= tx_in.chan;
		line_data <= tx_in.data;
	end
	always @(negedge pclk)
		if (pv)
		begin
			if (line_chan == 8'h02 || line_chan == 8'h04 || line_chan == 8'h05)
			begin
				if (tx_out.data !== (g[24] ^ g[2] ^ inv))
					tx_err++;
				g = {g[30:0], g[24] ^ g[2]};
			end
			else
				chk({7'h00, tx_out.data}, {7'h00, line_data}, "slot altered");
		end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rdc(`IDX_SHIFT_LEN, 8'h18);
		rdc(`IDX_FB_TAP, 8'h02);
		rdc(`IDX_SEED0, 8'hFF);
		rdc(`IDX_DET_CTRL, 8'h00);
		apb(1'h0, 10'h300, 8'h00);
		chk({7'h00, rd_err}, 8'h01, "unmapped");
		for (int i = 0; i < 9; i++)
			apb(1'h1, cfg_a[i], cfg_d[i]);
		chk({5'h00, framer_sel}, 8'h01, "framer");
		chk({7'h00, diag_loopback}, 8'h01, "loopback");
		rdc(`IDX_DET_CTRL, 8'h82);
		for (int c = 1; c <= 72; c++)
		begin
			if (c <= 24 || c >= 49)
			begin
				apb(1'h1, `IDX_TX_DATA, 8'h00);
				apb(1'h1, `IDX_TX_CHAN, 8'(c));
			end
			if (c <= 24)
			begin
				apb(1'h1, `IDX_RX_DATA, 8'h00);
				apb(1'h1, `IDX_RX_CHAN, 8'(c));
			end
		end
		for (int c = 2; c <= 5; c++)
			if (c != 3)
			begin
				apb(1'h1, `IDX_TX_DATA, 8'h08);
				apb(1'h1, `IDX_TX_CHAN, 8'(c));
				apb(1'h1, `IDX_RX_DATA, 8'h08);
				apb(1'h1, `IDX_RX_CHAN, 8'(c));
			end
		rdc(`IDX_RX_CHAN, 8'h05);
		$display("test setup done");
		run <= 1'h1;
		repeat (1500) @(posedge pclk);
		apb(1'h0, `IDX_DET_STAT, 8'h00);
		apb(1'h0, `IDX_DET_STAT, 8'h00);
		chk(rd & 8'h14, 8'h10, "not in sync");
		chk(8'(tx_err), 8'h00, "pattern");
		$display("test sync done");
		for (int i = 0; i < 3; i++)
		begin
			apb(1'h1, `IDX_ERR_INJ, 8'h08);
			apb(1'h1, `IDX_ERR_INJ, 8'h00);
			repeat (60) @(posedge pclk);
		end
		repeat (400) @(posedge pclk);
		chk(8'(tx_err), 8'h03, "inject count");
		apb(1'h0, `IDX_DET_STAT, 8'h00);
		chk(rd & 8'h14, 8'h14, "no bit error");
		rdc(`IDX_INT_STAT, 8'h05);
		@(negedge pclk);
		chk({7'h00, irq}, 8'h00, "irq masked");
		apb(1'h1, `IDX_INT_MASK, 8'h04);
		@(negedge pclk);
		chk({7'h00, irq}, 8'h01, "irq missing");
		apb(1'h1, `IDX_INT_STAT, 8'h04);
		@(negedge pclk);
		chk({7'h00, irq}, 8'h00, "irq stuck");
		rdc(`IDX_INT_STAT, 8'h01);
		// Each flipped bit is seen directly and again at both feedback positions.
		apb(1'h1, `IDX_ERRCNT0, 8'h00);
		rdc(`IDX_ERRCNT0, 8'h09);
		for (int i = 1; i < 4; i++)
			rdc(10'(`IDX_ERRCNT0 + i), 8'h00);
		apb(1'h1, `IDX_ERRCNT0, 8'h00);
		rdc(`IDX_ERRCNT0, 8'h00);
		$display("test errors done");
		// Both inversions at once keep the looped pattern valid; the forced resync must lock again.
		apb(1'h1, `IDX_DET_CTRL, 8'h33);
		inv = 1'h1;
		repeat (800) @(posedge pclk);
		apb(1'h0, `IDX_DET_STAT, 8'h00);
		apb(1'h0, `IDX_DET_STAT, 8'h00);
		chk(rd & 8'h14, 8'h10, "no resync");
		chk(8'(tx_err), 8'h03, "inverted pattern");
		rdc(`IDX_INT_STAT, 8'h03);
		$display("test invert done");
		stop_test;
	end
endmodule : tb
